// *** drive_cmd_pkg.sv ***
`default_nettype none
package drive_cmd_pkg;

  // clock and millisecond timebase
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;

  // data widths
  localparam int DATA_W = 32;
  localparam int SHORT_W = 16;
  localparam int IN_W = 8;
  localparam int IN_SEL_W = 3;
  localparam int REG_SEL_W = 6;
  localparam int FIFO_DEPTH = 8;

  // reply delay setting, in milliseconds
  localparam int DELAY_W = 15;
  localparam logic [DELAY_W-1:0] REPLY_DELAY_DEFAULT = 15'h000a;
  localparam logic signed [DATA_W-1:0] REPLY_DELAY_MAX = 32'sh00007fff;

  // condition code values held in the read-only condition register
  localparam logic [7:0] CC_NONE = 8'h00;
  localparam logic [7:0] CC_TRUE = 8'h54;
  localparam logic [7:0] CC_FALSE = 8'h46;
  localparam logic [7:0] CC_LESS = 8'h4c;
  localparam logic [7:0] CC_GREATER = 8'h47;
  localparam logic [7:0] CC_EQUAL = 8'h45;

  // interval values
  localparam logic [DATA_W-1:0] ELAPSED_EMPTY = 32'h00000000;
  localparam logic [DATA_W-1:0] MS_SATURATE = 32'hffffffff;

  // buffered operations handed over by the command queue
  typedef enum logic [2:0] {
    OP_INPUT_TEST = 3'h0,
    OP_REG_COMPARE = 3'h1,
    OP_ELAPSED_POP = 3'h2,
    OP_CAPTURE_ARM = 3'h3,
    OP_DELAY_WRITE = 3'h4
  } op_t;

  typedef struct packed {
    op_t op;
    logic [REG_SEL_W-1:0] sel;
    logic level;
    logic is_short;
    logic signed [DATA_W-1:0] value;
  } cmd_t;

  // immediate halt request and the rate settings it chooses from
  typedef struct packed {
    logic use_alt;
    logic jogging;
    logic [DATA_W-1:0] max_rate;
    logic [DATA_W-1:0] move_rate;
    logic [DATA_W-1:0] jog_rate;
  } halt_t;

  // short registers sit in the low half and are sign extended
  function automatic logic signed [DATA_W-1:0] widen(input logic [DATA_W-1:0] v, input logic is_short);
    logic signed [DATA_W-1:0] r;
    r = is_short ? {{(DATA_W-SHORT_W){v[SHORT_W-1]}}, v[SHORT_W-1:0]} : v;
    return r;
  endfunction

endpackage
`default_nettype wire

// *** interval_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module interval_fifo
  import drive_cmd_pkg::*;
#(
  parameter int W = DATA_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // control
  input wire logic clear,
  input wire logic push,
  input wire logic [W-1:0] din,
  input wire logic pop,
  // status
  output logic [W-1:0] dout,
  output logic empty,
  output logic full
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] rd;
    logic [AW-1:0] wr;
    logic [CW-1:0] count;
  } fifo_state_t;

  fifo_state_t state_r;
  fifo_state_t state_nxt;
  logic do_pop;
  logic do_push;

  // a full store drops new intervals unless a pop frees a slot this cycle
  always_comb begin
    state_nxt = state_r;
    do_pop = pop && (state_r.count != '0);
    do_push = push && ((state_r.count != CNT_FULL) || do_pop);
    if (clear) begin
      state_nxt.rd = '0;
      state_nxt.wr = '0;
      state_nxt.count = '0;
    end else begin
      if (do_pop) begin
        state_nxt.rd = state_r.rd + 1'b1;
      end
      if (do_push) begin
        state_nxt.mem[state_r.wr] = din;
        state_nxt.wr = state_r.wr + 1'b1;
      end
      if (do_push && !do_pop) begin
        state_nxt.count = state_r.count + 1'b1;
      end else if (do_pop && !do_push) begin
        state_nxt.count = state_r.count - 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign dout = state_r.mem[state_r.rd];
  assign empty = (state_r.count == '0);
  assign full = (state_r.count == CNT_FULL);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_fifo_full_drop: assert property (full && push && !pop && !clear |=> full && state_r.wr == $past(state_r.wr))
    else $error("interval pushed into a full store");
  a_fifo_clear_empty: assert property (clear |=> empty && state_r.rd == state_r.wr)
    else $error("store not empty after capture arm");
endmodule
`default_nettype wire

// *** reply_delay_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module reply_delay_timer
  import drive_cmd_pkg::*;
#(
  parameter int DW = DELAY_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // timebase and request
  input wire logic tick,
  input wire logic start,
  input wire logic [DW-1:0] delay,
  // result
  output logic go,
  output logic busy
);
  typedef enum logic [1:0] {
    T_IDLE = 2'b01,
    T_WAIT = 2'b10
  } tst_t;

  typedef struct packed {
    tst_t st;
    logic [DW-1:0] cnt;
    logic [DW-1:0] target;
    logic go;
  } tmr_state_t;

  tmr_state_t state_r;
  tmr_state_t state_nxt;

  // the first tick may come early, so one extra tick keeps the wait at least the setting
  always_comb begin
    state_nxt = state_r;
    state_nxt.go = 1'b0;
    unique case (state_r.st)
      T_IDLE: begin
        if (start) begin
          if (delay == '0) begin
            state_nxt.go = 1'b1;
          end else begin
            state_nxt.st = T_WAIT;
            state_nxt.cnt = '0;
            state_nxt.target = delay;
          end
        end
      end
      T_WAIT: begin
        if (tick) begin
          if (state_r.cnt == state_r.target) begin
            state_nxt.go = 1'b1;
            state_nxt.st = T_IDLE;
          end else begin
            state_nxt.cnt = state_r.cnt + 1'b1;
          end
        end
      end
      default: state_nxt.st = T_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_r <= '0;
      state_r.st <= T_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign go = state_r.go;
  assign busy = (state_r.st == T_WAIT);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_reply_hold_off: assert property (start && !busy && delay != '0 |=> !go [*2])
    else $error("reply released before the transmit delay");
  a_reply_full_count: assert property (go && $past(busy) |-> $past(state_r.cnt) == $past(state_r.target))
    else $error("reply released before the tick count was reached");
endmodule
`default_nettype wire

// *** drive_cmd_exec.sv ***
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - plain halt is immediate, bypasses the queue, stops at the maximum slowdown rate
// - halt with D suffix uses move slowdown rate, or jog rate while jogging
// - a reply is released only after the programmed transmit delay has passed
// - transmit delay is 0 to 32767 ms, ten after reset
// - transmit delay is writable, readable and kept in non-volatile storage
// - input test sets condition code true on match, false otherwise
// - condition code is held in a read-only register for conditional jumps
// - register compare checks a data register against a value, setting condition code
// - each trigger pushes the milliseconds elapsed since the previous trigger or arm, dropped when the store is full
// - interval store is a first-in first-out of eight words
// - each pop moves the oldest interval into the elapsed result register
// - arming interval capture empties the interval store
// - popping an empty store writes zero to the elapsed result register
// - every trigger is counted in the event count register
// - halt ends only the executing buffered command, queued ones stay
module drive_cmd_exec
  import drive_cmd_pkg::*;
#(
  parameter int MS_CYCLES_P = MS_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // buffered commands from the queue
  input wire logic cmd_valid,
  input wire cmd_t cmd,
  input wire logic queue_busy,
  output logic cmd_ready,
  // immediate halt
  input wire logic halt_cmd,
  input wire halt_t halt,
  output logic halt_stop,
  output logic [DATA_W-1:0] halt_rate,
  output logic abort_current,
  // transmit delay and its non-volatile copy
  input wire logic nv_load_valid,
  input wire logic [DELAY_W-1:0] nv_load_value,
  input wire logic reply_req,
  output logic reply_go,
  output logic reply_pending,
  output logic [DELAY_W-1:0] reply_delay_value,
  output logic nv_store,
  // inputs and data registers
  input wire logic [IN_W-1:0] in_pins,
  output logic [REG_SEL_W-1:0] reg_rd_sel,
  input wire logic [DATA_W-1:0] reg_rd_data,
  output logic [7:0] cond_code,
  // interval capture
  output logic [DATA_W-1:0] elapsed_result,
  output logic [DATA_W-1:0] event_count,
  output logic capture_armed
);
  localparam int PW = $clog2(MS_CYCLES_P + 1);
  localparam logic [PW-1:0] PRESC_LAST = PW'(MS_CYCLES_P - 1);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_REG_WAIT = 2'b10
  } st_t;

  typedef struct packed {
    st_t st;
    logic ready;
    cmd_t cmd;
    logic [PW-1:0] presc;
    logic tick;
    logic [DELAY_W-1:0] delay;
    logic nv_store;
    logic halt_stop;
    logic [DATA_W-1:0] halt_rate;
    logic abort;
    logic [7:0] cc;
    logic [REG_SEL_W-1:0] rd_sel;
    logic [DATA_W-1:0] elapsed;
    logic [DATA_W-1:0] events;
    logic [DATA_W-1:0] interval;
    logic armed;
    logic [IN_SEL_W-1:0] trig_sel;
    logic trig_level;
    logic trig_prev;
  } state_t;

  state_t state_r;
  state_t state_nxt;

  logic accept;
  logic trig_now;
  logic trig_event;
  logic in_match;
  logic fifo_push;
  logic fifo_pop;
  logic fifo_clear;
  logic fifo_empty;
  logic fifo_full;
  logic [DATA_W-1:0] fifo_head;
  logic signed [DATA_W-1:0] cmp_reg;
  logic signed [DATA_W-1:0] cmp_val;
  logic [DATA_W-1:0] interval_start;

  // interval store
  interval_fifo #(
    .W(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .clear(fifo_clear),
    .push(fifo_push),
    .din(state_r.interval),
    .pop(fifo_pop),
    .dout(fifo_head),
    .empty(fifo_empty),
    .full(fifo_full)
  );

  // reply turnaround timer, counts millisecond ticks
  reply_delay_timer #(
    .DW(DELAY_W)
  ) u_timer (
    .clk(clk),
    .nrst(nrst),
    .tick(state_r.tick),
    .start(reply_req),
    .delay(state_r.delay),
    .go(reply_go),
    .busy(reply_pending)
  );

  // helpers shared by next-state logic and checks
  assign accept = cmd_valid && state_r.ready && (state_r.st == ST_IDLE);
  assign trig_now = in_pins[state_r.trig_sel];
  assign trig_event = state_r.armed && (trig_now == state_r.trig_level) && (state_r.trig_prev != state_r.trig_level);
  assign in_match = (in_pins[cmd.sel[IN_SEL_W-1:0]] == cmd.level);
  assign cmp_reg = widen(reg_rd_data, state_r.cmd.is_short);
  assign cmp_val = widen(state_r.cmd.value, state_r.cmd.is_short);
  // a tick landing with a trigger or arm opens the new interval, so no millisecond is lost
  assign interval_start = {{(DATA_W-1){1'b0}}, state_r.tick};

  // next state of the whole block
  always_comb begin
    state_nxt = state_r;
    state_nxt.tick = 1'b0;
    state_nxt.nv_store = 1'b0;
    state_nxt.halt_stop = 1'b0;
    state_nxt.abort = 1'b0;
    fifo_push = 1'b0;
    fifo_pop = 1'b0;
    fifo_clear = 1'b0;

    // millisecond timebase
    if (state_r.presc == PRESC_LAST) begin
      state_nxt.presc = '0;
      state_nxt.tick = 1'b1;
    end else begin
      state_nxt.presc = state_r.presc + 1'b1;
    end

    // halt skips the queue; only the running command is aborted
    if (halt_cmd) begin
      state_nxt.halt_stop = 1'b1;
      state_nxt.abort = 1'b1;
      if (!halt.use_alt) begin
        state_nxt.halt_rate = halt.max_rate;
      end else if (halt.jogging) begin
        state_nxt.halt_rate = halt.jog_rate;
      end else begin
        state_nxt.halt_rate = halt.move_rate;
      end
    end

    // stored setting restored after power up
    if (nv_load_valid) begin
      state_nxt.delay = nv_load_value;
    end

    // interval timer saturates rather than wrap to a short bogus value
    if (state_r.tick && (state_r.interval != MS_SATURATE)) begin
      state_nxt.interval = state_r.interval + 1'b1;
    end
    state_nxt.trig_prev = trig_now;
    if (trig_event) begin
      fifo_push = 1'b1;
      state_nxt.interval = interval_start;
      state_nxt.events = state_r.events + 1'b1;
    end

    // buffered command execution
    unique case (state_r.st)
      ST_IDLE: begin
        if (accept) begin
          unique case (cmd.op)
            OP_INPUT_TEST: begin
              state_nxt.cc = in_match ? CC_TRUE : CC_FALSE;
            end
            OP_REG_COMPARE: begin
              state_nxt.cmd = cmd;
              state_nxt.rd_sel = cmd.sel;
              state_nxt.st = ST_REG_WAIT;
            end
            OP_ELAPSED_POP: begin
              fifo_pop = !fifo_empty;
              state_nxt.elapsed = fifo_empty ? ELAPSED_EMPTY : fifo_head;
            end
            OP_CAPTURE_ARM: begin
              fifo_clear = 1'b1;
              state_nxt.armed = 1'b1;
              state_nxt.trig_sel = cmd.sel[IN_SEL_W-1:0];
              state_nxt.trig_level = cmd.level;
              state_nxt.trig_prev = in_pins[cmd.sel[IN_SEL_W-1:0]];
              state_nxt.interval = interval_start;
            end
            OP_DELAY_WRITE: begin
              // out-of-range settings are ignored and the old value stays
              if ((cmd.value >= 0) && (cmd.value <= REPLY_DELAY_MAX)) begin
                state_nxt.delay = cmd.value[DELAY_W-1:0];
                state_nxt.nv_store = 1'b1;
              end
            end
            default: state_nxt.st = ST_IDLE;
          endcase
        end
      end
      ST_REG_WAIT: begin
        // register file answers one cycle after the select is registered
        if (cmp_reg < cmp_val) begin
          state_nxt.cc = CC_LESS;
        end else if (cmp_reg > cmp_val) begin
          state_nxt.cc = CC_GREATER;
        end else begin
          state_nxt.cc = CC_EQUAL;
        end
        state_nxt.st = ST_IDLE;
      end
      default: state_nxt.st = ST_IDLE;
    endcase

    // next buffered command waits until the preceding one is done
    state_nxt.ready = (state_nxt.st == ST_IDLE) && !queue_busy;
  end

  // state register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_r <= '0;
      state_r.st <= ST_IDLE;
      state_r.delay <= REPLY_DELAY_DEFAULT;
      state_r.cc <= CC_NONE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // outputs straight from the state register
  assign cmd_ready = state_r.ready;
  assign halt_stop = state_r.halt_stop;
  assign halt_rate = state_r.halt_rate;
  assign abort_current = state_r.abort;
  assign reply_delay_value = state_r.delay;
  assign nv_store = state_r.nv_store;
  assign reg_rd_sel = state_r.rd_sel;
  assign cond_code = state_r.cc;
  assign elapsed_result = state_r.elapsed;
  assign event_count = state_r.events;
  assign capture_armed = state_r.armed;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_halt_plain;
    halt_cmd && !halt.use_alt;
  endsequence

  sequence s_halt_alt;
    halt_cmd && halt.use_alt;
  endsequence

  a_halt_max_rate: assert property (s_halt_plain |=> halt_stop && abort_current && halt_rate == $past(halt.max_rate))
    else $error("plain halt did not use the maximum slowdown rate");
  a_halt_alt_rate: assert property (s_halt_alt |=> halt_rate == ($past(halt.jogging) ? $past(halt.jog_rate) : $past(halt.move_rate)))
    else $error("suffixed halt chose the wrong slowdown rate");
  a_delay_reset_val: assert property ($past(nrst) == 1'b0 |-> reply_delay_value == REPLY_DELAY_DEFAULT)
    else $error("transmit delay not at its default after reset");
  a_input_test_cc: assert property (accept && cmd.op == OP_INPUT_TEST |=> cond_code == ($past(in_match) ? CC_TRUE : CC_FALSE))
    else $error("input test set the wrong condition code");
  a_compare_two_cycle: assert property (accept && cmd.op == OP_REG_COMPARE |=> !cmd_ready ##1 (cond_code == CC_LESS || cond_code == CC_GREATER || cond_code == CC_EQUAL))
    else $error("register compare did not settle the condition code");
  a_pop_oldest: assert property (accept && cmd.op == OP_ELAPSED_POP && !fifo_empty |=> elapsed_result == $past(fifo_head))
    else $error("pop did not deliver the oldest interval");
  a_pop_empty_zero: assert property (accept && cmd.op == OP_ELAPSED_POP && fifo_empty |=> elapsed_result == ELAPSED_EMPTY)
    else $error("pop of an empty store did not give zero");
  a_trigger_count: assert property (trig_event && !(accept && cmd.op == OP_CAPTURE_ARM) |=> event_count == $past(event_count) + 1'b1)
    else $error("trigger not counted");
  a_queue_order: assert property (accept |-> $past(!queue_busy))
    else $error("buffered command taken while the previous one ran");
endmodule
`default_nettype wire

// *** host_side_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_side_model
  import drive_cmd_pkg::*;
(
  // clock
  input wire logic clk,
  // data register read port
  input wire logic [REG_SEL_W-1:0] reg_rd_sel,
  output logic [DATA_W-1:0] reg_rd_data,
  // non-volatile delay store
  input wire logic nv_store,
  input wire logic [DELAY_W-1:0] reply_delay_value
);
  logic [DATA_W-1:0] regs [64];
  logic [DELAY_W-1:0] nv_mem = 15'h0000;
  // bench loads compare registers with full 32-bit random values, short registers included
  assign reg_rd_data = regs[reg_rd_sel];
  // a save outlives a drive reset, as flash would
  always @(posedge clk) begin
    if (nv_store === 1'b1) begin
      nv_mem <= reply_delay_value;
    end
  end
  // registers start cleared so no unknown reaches the compare
  initial begin
    for (int i = 0; i < 64; i++) begin
      regs[i] = 32'h00000000;
    end
  end
endmodule
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  import drive_cmd_pkg::*;
  // short millisecond so delays and intervals stay cheap
  localparam int MSC = 10;
  logic clk, nrst, cmd_valid, queue_busy, halt_cmd, nv_load_valid, reply_req;
  cmd_t cmd;
  halt_t halt;
  logic [DELAY_W-1:0] nv_load_value, reply_delay_value;
  logic [IN_W-1:0] in_pins;
  logic cmd_ready, halt_stop, abort_current, reply_go, reply_pending, nv_store, capture_armed;
  logic [DATA_W-1:0] halt_rate, reg_rd_data, elapsed_result, event_count, r, v, e;
  logic [REG_SEL_W-1:0] reg_rd_sel;
  logic [7:0] cond_code, prev_cc;
  logic [31:0] seed = 32'hcab8e3be;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  int n_store = 0;
  int fifo_q[$];
  int ev_model, rv, tv, k;

  drive_cmd_exec #(.MS_CYCLES_P(MSC)) dut (
    .clk, .nrst, .cmd_valid, .cmd, .queue_busy, .cmd_ready,
    .halt_cmd, .halt, .halt_stop, .halt_rate, .abort_current,
    .nv_load_valid, .nv_load_value, .reply_req, .reply_go, .reply_pending,
    .reply_delay_value, .nv_store, .in_pins, .reg_rd_sel, .reg_rd_data,
    .cond_code, .elapsed_result, .event_count, .capture_armed
  );
  host_side_model host (.clk, .reg_rd_sel, .reg_rd_data, .nv_store, .reply_delay_value);

  // free running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // a hang ends the run as a failure
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, cycles, 0);
      give_verdict();
    end
  end

  // save pulses stand one cycle, so count them where they are settled
  always @(negedge clk) begin
    if (nv_store === 1'b1) begin
      n_store++;
    end
  end

  task automatic do_reset();
    nrst <= 1'b0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1;
  endtask

  // offer one buffered command and return one cycle after it is taken
  task automatic send(input op_t op, input int sel, input int lvl, input logic sh,
                      input logic signed [DATA_W-1:0] val);
    int n;
    n = 0;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= '{op: op, sel: REG_SEL_W'(sel), level: lvl[0], is_short: sh, value: val};
    do begin
      @(posedge clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 300);
    cmd_valid <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic do_halt(input int m);
    r = rnd();
    v = rnd();
    e = rnd();
    @(posedge clk);
    halt_cmd <= 1'b1;
    halt <= '{use_alt: m > 0, jogging: m == 2, max_rate: r, move_rate: v, jog_rate: e};
    @(posedge clk);
    halt_cmd <= 1'b0;
    #1;
    check(halt_stop, 1);
    check(abort_current, 1);
    check(halt_rate, m == 0 ? r : m == 1 ? v : e);
    @(posedge clk);
    #1;
    check(abort_current, 0);
  endtask

  task automatic reply_time(input int d);
    int n;
    n = 1;
    @(posedge clk);
    reply_req <= 1'b1;
    @(posedge clk);
    reply_req <= 1'b0;
    #1;
    check(reply_pending, d != 0);
    while (reply_go !== 1'b1 && n < 2000) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(d == 0 ? n == 1 : n >= d * MSC && n <= (d + 1) * MSC + 2, 1);
    check(reply_pending, 0);
  endtask

  // one trigger on input 2 after ms milliseconds
  task automatic trig(input int ms);
    repeat (2) @(posedge clk);
    in_pins[2] <= 1'b0;
    repeat (ms * MSC - 2) @(posedge clk);
    in_pins[2] <= 1'b1;
    if (fifo_q.size() < 8) begin
      fifo_q.push_back(ms);
    end
    ev_model++;
  endtask

  initial begin
    nrst = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    queue_busy = 1'b0;
    halt_cmd = 1'b0;
    halt = '0;
    nv_load_valid = 1'b0;
    nv_load_value = '0;
    reply_req = 1'b0;
    in_pins = '0;
    ev_model = 0;
    do_reset();
    check(reply_delay_value, 10);
    check(cond_code, CC_NONE);
    $display("reset values done");
    for (int m = 0; m < 3; m++) begin
      do_halt(m);
    end
    $display("halt done");
    // every input against both levels
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      in_pins <= IN_W'(rnd());
      @(posedge clk);
      send(OP_INPUT_TEST, i % 8, i / 8, 1'b0, 0);
      check(cond_code, (in_pins[i % 8] == i / 8) ? CC_TRUE : CC_FALSE);
    end
    $display("input test done");
    for (int j = 0; j < 6; j++) begin
      r = rnd();
      v = rnd();
      rv = j[0] ? int'($signed(r[15:0])) : int'($signed(r));
      tv = j[0] ? int'($signed(v[15:0])) : int'($signed(v));
      if (tv == -32768 || tv == -2147483647 - 1) tv = 1;
      if (j >= 4) tv = rv;
      host.regs[j * 7 + 1] = r;
      send(OP_REG_COMPARE, 6'(j * 7 + 1), 1'b0, j[0], tv);
      @(posedge clk);
      #1;
      check(cond_code, rv < tv ? CC_LESS : rv > tv ? CC_GREATER : CC_EQUAL);
      check(reg_rd_sel, j * 7 + 1);
    end
    $display("register compare done");
    // a running command holds the next one back
    prev_cc = cond_code;
    @(posedge clk);
    queue_busy <= 1'b1;
    in_pins <= 8'h01;
    fork
      send(OP_INPUT_TEST, 0, 1'b1, 1'b0, 0);
      begin
        repeat (8) @(posedge clk);
        #1;
        check(cmd_ready, 0);
        check(cond_code, prev_cc);
        @(posedge clk);
        queue_busy <= 1'b0;
      end
    join
    check(cond_code, CC_TRUE);
    $display("queue order done");
    reply_time(10);
    send(OP_DELAY_WRITE, 0, 1'b0, 1'b0, 0);
    check(reply_delay_value, 0);
    check(n_store, 1);
    reply_time(0);
    send(OP_DELAY_WRITE, 0, 1'b0, 1'b0, 32767);
    check(reply_delay_value, 15'h7fff);
    send(OP_DELAY_WRITE, 0, 1'b0, 1'b0, 32768);
    check(n_store, 2);
    send(OP_DELAY_WRITE, 0, 1'b0, 1'b0, -1);
    check(reply_delay_value, 15'h7fff);
    send(OP_DELAY_WRITE, 0, 1'b0, 1'b0, 3);
    reply_time(3);
    do_reset();
    check(reply_delay_value, 10);
    @(posedge clk);
    nv_load_valid <= 1'b1;
    nv_load_value <= host.nv_mem;
    @(posedge clk);
    nv_load_valid <= 1'b0;
    @(posedge clk);
    #1;
    check(reply_delay_value, 3);
    $display("reply delay done");
    in_pins <= 8'h00;
    send(OP_CAPTURE_ARM, 2, 1'b1, 1'b0, 0);
    check(capture_armed, 1);
    fifo_q.delete();
    for (int t = 0; t < 9; t++) begin
      trig(1 + t % 3);
    end
    repeat (4) @(posedge clk);
    #1;
    check(event_count, ev_model);
    for (int t = 0; t < 10; t++) begin
      send(OP_ELAPSED_POP, 0, 1'b0, 1'b0, 0);
      k = fifo_q.size() ? fifo_q.pop_front() : 0;
      if (t == 0) begin
        check(elapsed_result >= k - 1 && elapsed_result <= k + 1, 1);
      end else begin
        check(elapsed_result, k);
      end
    end
    trig(2);
    trig(2);
    send(OP_CAPTURE_ARM, 2, 1'b1, 1'b0, 0);
    send(OP_ELAPSED_POP, 0, 1'b0, 1'b0, 0);
    check(elapsed_result, ELAPSED_EMPTY);
    check(event_count, ev_model);
    $display("interval capture done");
    give_verdict();
  end
endmodule
`default_nettype wire
